/* File: gpio_cfg_defs.svh */
// gpio_cfg_defs.svh: offsets, indexes, field masks and reset values of the
// gpio configuration register block.
// assumes inclusion by bare name from the package and the design module.
`ifndef GPIO_CFG_DEFS_SVH
`define GPIO_CFG_DEFS_SVH

// ----------------------------------------------------------------------------
// bus byte offsets (one aligned 32-bit word each)
// ----------------------------------------------------------------------------
`define OFS_CFG_CTRL   8'h00
`define OFS_CFG_INDEX  8'h04
`define OFS_CFG_DATA   8'h08
`define OFS_PORT3_OUT  8'h0C
`define OFS_PORT4_OUT  8'h10
`define OFS_PORT3_IN   8'h14
`define OFS_PORT4_IN   8'h18
`define OFS_MISC_CTRL  8'h1C

// ----------------------------------------------------------------------------
// indexes loaded into the config index register
// ----------------------------------------------------------------------------
`define IDX_PORT3_DIR  8'h35
`define IDX_PORT3_POL  8'h36
`define IDX_PORT4_DIR  8'h37
`define IDX_PORT4_POL  8'h38
`define IDX_PORT1_OTYP 8'h39

// ----------------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------------
`define OTYP_WR_MASK   8'hCE
`define REG8_RESET     8'h00
`define PIN_OE_N_RESET 8'hFF
`define CTRL_CFG_BIT   0
`define MISC_FLOPPY_BIT 0
`define MISC_ALT_BIT   1
`define OTYP_ALT_BIT   1
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

/* File: gpio_cfg_pkg.sv */
// gpio_cfg_pkg.sv: state type of the gpio configuration register block.
// assumes gpio_cfg_defs.svh is on the include path.
`include "gpio_cfg_defs.svh"

package gpio_cfg_pkg;

   // ----------------------------------------------------------------------------
   // whole state of the block, one flop vector
   // ----------------------------------------------------------------------------
   typedef struct packed {
      logic        cfg_state;
      logic [7:0]  index;
      logic [7:0]  dir3;
      logic [7:0]  pol3;
      logic [7:0]  dir4;
      logic [7:0]  pol4;
      logic [7:0]  otype1;
      logic [7:0]  out3;
      logic [7:0]  out4;
      logic        floppy_opt;
      logic        alt_sel;
      logic [7:0]  s1_3;
      logic [7:0]  s2_3;
      logic [7:0]  s3_3;
      logic [7:0]  in3;
      logic [7:0]  s1_4;
      logic [7:0]  s2_4;
      logic [7:0]  s3_4;
      logic [7:0]  in4;
      logic        aw_have;
      logic [7:0]  aw_addr;
      logic        w_have;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic [7:0]  pin3_o;
      logic [7:0]  pin3_oe_n;
      logic [7:0]  pin4_o;
      logic [7:0]  pin4_oe_n;
      logic [7:0]  p1_od;
   } gpio_state_s;

endpackage : gpio_cfg_pkg

/* File: gpio_port_config_regs.sv */
// gpio_port_config_regs.sv: port 3 / port 4 direction and polarity, port 1
// output type, reached over axi4-lite through a config index register.
// assumes one clock, synchronous active-high reset, pins from outside.
`timescale 1ns/10ps
`include "gpio_cfg_defs.svh"

module gpio_port_config_regs (
   // clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   // axi4-lite write address
   input  wire logic        awvalid_i,
   output logic             awready_o,
   input  wire logic [7:0]  awaddr_i,
   // axi4-lite write data
   input  wire logic        wvalid_i,
   output logic             wready_o,
   input  wire logic [31:0] wdata_i,
   input  wire logic [3:0]  wstrb_i,
   // axi4-lite write response
   output logic             bvalid_o,
   input  wire logic        bready_i,
   output logic [1:0]       bresp_o,
   // axi4-lite read address
   input  wire logic        arvalid_i,
   output logic             arready_o,
   input  wire logic [7:0]  araddr_i,
   // axi4-lite read data
   output logic             rvalid_o,
   input  wire logic        rready_i,
   output logic [31:0]      rdata_o,
   output logic [1:0]       rresp_o,
   // port 3 pins
   input  wire logic [7:0]  port3_pins_i,
   output logic [7:0]       port3_pins_o,
   output logic [7:0]       port3_pins_oe_n_o,
   // port 4 pins
   input  wire logic [7:0]  port4_pins_i,
   output logic [7:0]       port4_pins_o,
   output logic [7:0]       port4_pins_oe_n_o,
   // port 1 driver type, 1 = open drain
   output logic [7:0]       port1_open_drain_o
);

   gpio_cfg_pkg::gpio_state_s s_r;
   gpio_cfg_pkg::gpio_state_s s_nxt;
   logic                      do_wr;

   // direction registers clear to zero, so every pin must leave reset as an input with its enable high
   localparam gpio_cfg_pkg::gpio_state_s rst_state = '{
      pin3_oe_n: `PIN_OE_N_RESET,
      pin4_oe_n: `PIN_OE_N_RESET,
      default:   '0
   };

   // ----------------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------------

   // a write is carried out once both address and data are held
   assign do_wr = s_r.aw_have & s_r.w_have;

   always_comb begin
      logic [7:0]  wd;
      logic        wb0;
      logic        idx_ok;
      logic [31:0] rd;
      logic [1:0]  rr;
      wd     = s_r.w_data[7:0];
      wb0    = s_r.w_strb[0];
      rd     = 32'h0000_0000;
      rr     = `RESP_OKAY;
      s_nxt  = s_r;
      // index is only honoured for the five known registers in config state
      idx_ok = s_r.cfg_state & ((s_r.index == `IDX_PORT3_DIR) | (s_r.index == `IDX_PORT3_POL) |
                                (s_r.index == `IDX_PORT4_DIR) | (s_r.index == `IDX_PORT4_POL) |
                                (s_r.index == `IDX_PORT1_OTYP));

      // address and data are taken in either order and held
      if (awvalid_i && s_r.awready) begin
         s_nxt.aw_have = 1'b1;
         s_nxt.aw_addr = awaddr_i;
      end
      if (wvalid_i && s_r.wready) begin
         s_nxt.w_have = 1'b1;
         s_nxt.w_data = wdata_i;
         s_nxt.w_strb = wstrb_i;
      end
      if (s_r.bvalid && bready_i) begin
         s_nxt.bvalid = 1'b0;
      end

      // register writes; only the low byte lane carries data
      if (do_wr) begin
         s_nxt.aw_have = 1'b0;
         s_nxt.w_have  = 1'b0;
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = `RESP_OKAY;
         unique case (s_r.aw_addr)
            `OFS_CFG_CTRL: begin
               if (wb0) s_nxt.cfg_state = wd[`CTRL_CFG_BIT];
            end
            `OFS_CFG_INDEX: begin
               if (wb0) s_nxt.index = wd;
            end
            `OFS_CFG_DATA: begin
               if (!idx_ok) begin
                  s_nxt.bresp = `RESP_SLVERR;
               end else if (wb0) begin
                  unique case (s_r.index)
                     `IDX_PORT3_DIR: s_nxt.dir3   = wd;
                     `IDX_PORT3_POL: s_nxt.pol3   = wd;
                     `IDX_PORT4_DIR: s_nxt.dir4   = wd;
                     `IDX_PORT4_POL: s_nxt.pol4   = wd;
                     default:        s_nxt.otype1 = wd & `OTYP_WR_MASK;
                  endcase
               end
            end
            `OFS_PORT3_OUT: begin
               if (wb0) s_nxt.out3 = wd;
            end
            `OFS_PORT4_OUT: begin
               if (wb0) s_nxt.out4 = wd;
            end
            `OFS_MISC_CTRL: begin
               if (wb0) begin
                  s_nxt.floppy_opt = wd[`MISC_FLOPPY_BIT];
                  s_nxt.alt_sel    = wd[`MISC_ALT_BIT];
               end
            end
            `OFS_PORT3_IN, `OFS_PORT4_IN: begin
               s_nxt.bresp = `RESP_OKAY; // read-only, write ignored
            end
            default: s_nxt.bresp = `RESP_SLVERR;
         endcase
      end

      // register reads
      unique case (araddr_i)
         `OFS_CFG_CTRL:  rd[0]   = s_r.cfg_state;
         `OFS_CFG_INDEX: rd[7:0] = s_r.index;
         `OFS_CFG_DATA: begin
            if (!idx_ok) begin
               rr = `RESP_SLVERR;
            end else begin
               unique case (s_r.index)
                  `IDX_PORT3_DIR: rd[7:0] = s_r.dir3;
                  `IDX_PORT3_POL: rd[7:0] = s_r.pol3;
                  `IDX_PORT4_DIR: rd[7:0] = s_r.dir4;
                  `IDX_PORT4_POL: rd[7:0] = s_r.pol4;
                  default:        rd[7:0] = s_r.otype1 & `OTYP_WR_MASK;
               endcase
            end
         end
         `OFS_PORT3_OUT: rd[7:0] = s_r.out3;
         `OFS_PORT4_OUT: rd[7:0] = s_r.out4;
         `OFS_PORT3_IN:  rd[7:0] = s_r.in3 ^ s_r.pol3;
         `OFS_PORT4_IN:  rd[7:0] = s_r.in4 ^ s_r.pol4;
         `OFS_MISC_CTRL: rd[1:0] = {s_r.alt_sel, s_r.floppy_opt};
         default:        rr      = `RESP_SLVERR;
      endcase
      if (arvalid_i && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata  = rd;
         s_nxt.rresp  = rr;
      end else if (s_r.rvalid && rready_i) begin
         s_nxt.rvalid = 1'b0;
      end

      // one write and one read in flight; ready drops while an answer waits
      s_nxt.awready = ~s_nxt.aw_have & ~s_nxt.bvalid;
      s_nxt.wready  = ~s_nxt.w_have & ~s_nxt.bvalid;
      s_nxt.arready = ~s_nxt.rvalid;

      // three-stage pin sampling; a bit moves only when stages two and three agree
      s_nxt.s1_3 = port3_pins_i;
      s_nxt.s2_3 = s_r.s1_3;
      s_nxt.s3_3 = s_r.s2_3;
      s_nxt.in3  = (s_r.s2_3 & ~(s_r.s2_3 ^ s_r.s3_3)) | (s_r.in3 & (s_r.s2_3 ^ s_r.s3_3));
      s_nxt.s1_4 = port4_pins_i;
      s_nxt.s2_4 = s_r.s1_4;
      s_nxt.s3_4 = s_r.s2_4;
      s_nxt.in4  = (s_r.s2_4 & ~(s_r.s2_4 ^ s_r.s3_4)) | (s_r.in4 & (s_r.s2_4 ^ s_r.s3_4));

      // pin drive follows the new register values in the same edge
      s_nxt.pin3_o    = s_nxt.out3 ^ s_nxt.pol3;
      s_nxt.pin3_oe_n = ~s_nxt.dir3;
      s_nxt.pin4_o    = s_nxt.out4 ^ s_nxt.pol4;
      s_nxt.pin4_oe_n = ~s_nxt.dir4;
      s_nxt.p1_od     = s_nxt.otype1 & `OTYP_WR_MASK;
      if (s_nxt.alt_sel) begin
         s_nxt.p1_od[`OTYP_ALT_BIT] = s_nxt.floppy_opt;
      end
   end

   // ----------------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------------

   // registers clear to zero; only the pin enables sit high so no pin drives during reset
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         s_r <= rst_state;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs taken straight from the state flops
   assign awready_o          = s_r.awready;
   assign wready_o           = s_r.wready;
   assign bvalid_o           = s_r.bvalid;
   assign bresp_o            = s_r.bresp;
   assign arready_o          = s_r.arready;
   assign rvalid_o           = s_r.rvalid;
   assign rdata_o            = s_r.rdata;
   assign rresp_o            = s_r.rresp;
   assign port3_pins_o       = s_r.pin3_o;
   assign port3_pins_oe_n_o  = s_r.pin3_oe_n;
   assign port4_pins_o       = s_r.pin4_o;
   assign port4_pins_oe_n_o  = s_r.pin4_oe_n;
   assign port1_open_drain_o = s_r.p1_od;

   // ----------------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   a_cfg_gate_write: assert property (do_wr && !s_r.cfg_state && s_r.aw_addr == `OFS_CFG_DATA |=>
      $stable(s_r.dir3) && $stable(s_r.pol3) && $stable(s_r.dir4) && $stable(s_r.pol4) && $stable(s_r.otype1)
      && bresp_o == `RESP_SLVERR)
      else $error("config data write outside config state took effect");

   a_dir3_write_oe: assert property (do_wr && s_r.cfg_state && s_r.aw_addr == `OFS_CFG_DATA
      && s_r.index == `IDX_PORT3_DIR && s_r.w_strb[0] |=> port3_pins_oe_n_o == ~$past(s_r.w_data[7:0]))
      else $error("port 3 direction write did not reach the output enables");

   a_pol3_drive: assert property (port3_pins_o == (s_r.out3 ^ s_r.pol3))
      else $error("port 3 drive does not follow polarity");

   a_dir4_oe_map: assert property ($changed(s_r.dir4) |->
      $past(do_wr) && port4_pins_oe_n_o == ~s_r.dir4)
      else $error("port 4 direction changed without a write");

   a_dir4_write_oe: assert property (do_wr && s_r.cfg_state && s_r.aw_addr == `OFS_CFG_DATA
      && s_r.index == `IDX_PORT4_DIR && s_r.w_strb[0] |=> port4_pins_oe_n_o == ~$past(s_r.w_data[7:0]))
      else $error("port 4 direction write did not reach the output enables");

   a_pol4_drive: assert property ($changed(s_r.pol4) |-> port4_pins_o == (s_r.out4 ^ s_r.pol4))
      else $error("port 4 drive does not follow polarity");

   a_otype_reserved: assert property ((port1_open_drain_o & ~`OTYP_WR_MASK) == 8'h00
      && (s_r.otype1 & ~`OTYP_WR_MASK) == 8'h00)
      else $error("reserved output type bits set");

   a_reset_clears: assert property ($past(rst_i) |-> s_r.dir3 == `REG8_RESET && s_r.pol3 == `REG8_RESET
      && s_r.dir4 == `REG8_RESET && s_r.pol4 == `REG8_RESET && s_r.otype1 == `REG8_RESET
      && port3_pins_oe_n_o == 8'hFF)
      else $error("gpio registers not zero after reset");

   a_alt_drive_type: assert property (s_r.alt_sel |->
      port1_open_drain_o[`OTYP_ALT_BIT] == s_r.floppy_opt)
      else $error("alternate pin driver type not from floppy option");

   a_resv_read_zero: assert property (rvalid_o && $rose(rvalid_o) && $past(araddr_i) == `OFS_CFG_DATA
      && $past(s_r.index) == `IDX_PORT1_OTYP |-> (rdata_o & ~{24'h000000, `OTYP_WR_MASK}) == 32'h0000_0000)
      else $error("reserved bits read non-zero");

   // per bit: a moved bit must have had agreeing stages and take the second stage's value
   a_in3_filtered: assert property ($changed(s_r.in3) |->
      ((s_r.in3 ^ $past(s_r.in3)) & ($past(s_r.s2_3) ^ $past(s_r.s3_3))) == 8'h00
      && ((s_r.in3 ^ $past(s_r.in3)) & (s_r.in3 ^ $past(s_r.s2_3))) == 8'h00)
      else $error("port 3 input moved without agreeing samples");

   a_write_answers: assert property (do_wr |=> bvalid_o [*1] ##0 !awready_o && !wready_o)
      else $error("write not answered next cycle");

   a_otype_write: assert property (do_wr && s_r.cfg_state && s_r.aw_addr == `OFS_CFG_DATA
      && s_r.index == `IDX_PORT1_OTYP && s_r.w_strb[0] |=>
      s_r.otype1 == ($past(s_r.w_data[7:0]) & `OTYP_WR_MASK))
      else $error("output type write did not land with reserved bits clear");

   // read path: refused window reads and polarity on the sampled inputs
   a_read_refused: assert property (arvalid_i && arready_o && araddr_i == `OFS_CFG_DATA
      && !s_r.cfg_state |=> rresp_o == `RESP_SLVERR && rdata_o == 32'h0000_0000)
      else $error("config data read outside config state not refused");

   a_in3_read_pol: assert property (arvalid_i && arready_o && araddr_i == `OFS_PORT3_IN |=>
      rdata_o == {24'h000000, $past(s_r.in3) ^ $past(s_r.pol3)})
      else $error("port 3 input read does not apply polarity");

   a_in4_read_pol: assert property (arvalid_i && arready_o && araddr_i == `OFS_PORT4_IN |=>
      rdata_o == {24'h000000, $past(s_r.in4) ^ $past(s_r.pol4)})
      else $error("port 4 input read does not apply polarity");

endmodule : gpio_port_config_regs

/* File: tb.sv */
// tb.sv: self-checking bench for the gpio configuration register block.
// assumes gpio_cfg_defs.svh on the include path and the design module compiled before.
`timescale 1ns/10ps
`include "gpio_cfg_defs.svh"

module tb;
   // ----------------------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------------------
   logic        core_clk_i = 1'b0;
   logic        rst_i;
   logic        awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o, bready_i;
   logic        arvalid_i, arready_o, rvalid_o, rready_i;
   logic [7:0]  awaddr_i, araddr_i;
   logic [31:0] wdata_i, rdata_o;
   logic [3:0]  wstrb_i;
   logic [1:0]  bresp_o, rresp_o;
   logic [7:0]  port3_pins_i, port3_pins_o, port3_pins_oe_n_o;
   logic [7:0]  port4_pins_i, port4_pins_o, port4_pins_oe_n_o;
   logic [7:0]  port1_open_drain_o;
   int          n_fail, tests_run;

   gpio_port_config_regs u_dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i),
      .awvalid_i(awvalid_i), .awready_o(awready_o), .awaddr_i(awaddr_i),
      .wvalid_i(wvalid_i), .wready_o(wready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
      .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o),
      .arvalid_i(arvalid_i), .arready_o(arready_o), .araddr_i(araddr_i),
      .rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o), .rresp_o(rresp_o),
      .port3_pins_i(port3_pins_i), .port3_pins_o(port3_pins_o), .port3_pins_oe_n_o(port3_pins_oe_n_o),
      .port4_pins_i(port4_pins_i), .port4_pins_o(port4_pins_o), .port4_pins_oe_n_o(port4_pins_oe_n_o),
      .port1_open_drain_o(port1_open_drain_o)
   );

   // 200 mhz clock
   always #2.5 core_clk_i = ~core_clk_i;

   // ----------------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------------
   task results;
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results

   task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk

   // sync reset held ten cycles; requests are taken from the second edge after release
   task do_reset;
      rst_i <= 1'b1;
      repeat (10) @(posedge core_clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
   endtask : do_reset

   // address and data offered together, each dropped at its own handshake; only the watchdog ends a hang
   task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, input logic [3:0] s = 4'hF);
      bit got;
      got = 0;
      @(posedge core_clk_i);
      awvalid_i <= 1'b1;
      awaddr_i  <= a;
      wvalid_i  <= 1'b1;
      wdata_i   <= d;
      wstrb_i   <= s;
      bready_i  <= 1'b1;
      while (!got) begin
         @(posedge core_clk_i);
         if (awvalid_i && awready_o) awvalid_i <= 1'b0;
         if (wvalid_i && wready_o) wvalid_i <= 1'b0;
         if (bvalid_o === 1'b1) begin
            r = bresp_o;
            bready_i <= 1'b0;
            got = 1;
            chk({awready_o, wready_o}, 2'b00, "write readies high while answer waits");
         end
      end
   endtask : wr

   task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      bit got;
      got = 0;
      @(posedge core_clk_i);
      arvalid_i <= 1'b1;
      araddr_i  <= a;
      rready_i  <= 1'b1;
      while (!got) begin
         @(posedge core_clk_i);
         if (arvalid_i && arready_o) arvalid_i <= 1'b0;
         if (rvalid_o === 1'b1) begin
            d = rdata_o;
            r = rresp_o;
            rready_i <= 1'b0;
            got = 1;
            chk(arready_o, 1'b0, "read ready high while answer waits");
         end
      end
   endtask : rd

   // indexed access: load the index, then go through the data window
   task cfg_wr(input logic [7:0] idx, input logic [7:0] d);
      logic [1:0] r;
      wr(`OFS_CFG_INDEX, {24'h0, idx}, r);
      wr(`OFS_CFG_DATA, {24'h0, d}, r);
      chk(r, `RESP_OKAY, "indexed write resp");
   endtask : cfg_wr

   task cfg_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      logic [1:0] r0;
      wr(`OFS_CFG_INDEX, {24'h0, idx}, r0);
      rd(`OFS_CFG_DATA, d, r);
   endtask : cfg_rd

   // ----------------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------------
   // outside config state the window refuses, and a refused write leaves no trace
   task t_denied;
      logic [31:0] d;
      logic [1:0]  r;
      wr(`OFS_CFG_INDEX, 32'h35, r);
      rd(`OFS_CFG_DATA, d, r);
      chk(r, `RESP_SLVERR, "read outside config");
      chk(d, 32'h0, "refused read data");
      wr(`OFS_CFG_DATA, 32'hFF, r);
      chk(r, `RESP_SLVERR, "write outside config");
      chk(port3_pins_oe_n_o, 8'hFF, "refused write kept pins input");
      rd(8'h20, d, r);
      chk(r, `RESP_SLVERR, "unmapped read");
      wr(`OFS_CFG_CTRL, 32'h1, r);
      cfg_rd(8'h3A, d, r);
      chk(r, `RESP_SLVERR, "index out of range");
   endtask : t_denied

   task t_reset_vals;
      logic [31:0] d;
      logic [1:0]  r;
      chk(port1_open_drain_o, 8'h00, "reset driver type");
      chk({port3_pins_oe_n_o, port4_pins_oe_n_o}, 16'hFFFF, "reset direction pins");
      for (int i = 8'h35; i <= 8'h39; i++) begin
         cfg_rd(i[7:0], d, r);
         chk(r, `RESP_OKAY, "reset read resp");
         chk(d, 32'h0, "reset value");
      end
   endtask : t_reset_vals

   // direction, polarity on drive and on sample; distinct data per port catches cross wiring
   task t_port(input bit p4);
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  dv, pv, ov, iv;
      dv = p4 ? 8'h3C : 8'hA5;
      pv = p4 ? 8'h81 : 8'h33;
      ov = p4 ? 8'hF0 : 8'h0F;
      iv = p4 ? 8'h5A : 8'h81;
      cfg_wr(p4 ? `IDX_PORT4_DIR : `IDX_PORT3_DIR, dv);
      chk(p4 ? port4_pins_oe_n_o : port3_pins_oe_n_o, {24'h0, ~dv}, "direction to enables");
      cfg_rd(p4 ? `IDX_PORT4_DIR : `IDX_PORT3_DIR, d, r);
      chk(d, {24'h0, dv}, "direction readback");
      wr(p4 ? `OFS_PORT4_OUT : `OFS_PORT3_OUT, {24'h0, ov}, r);
      chk(p4 ? port4_pins_o : port3_pins_o, ov, "plain drive");
      cfg_wr(p4 ? `IDX_PORT4_POL : `IDX_PORT3_POL, pv);
      chk(p4 ? port4_pins_o : port3_pins_o, ov ^ pv, "inverted drive");
      cfg_rd(p4 ? `IDX_PORT4_POL : `IDX_PORT3_POL, d, r);
      chk(d, {24'h0, pv}, "polarity readback");
      if (p4) port4_pins_i <= iv;
      else port3_pins_i <= iv;
      repeat (6) @(posedge core_clk_i);
      rd(p4 ? `OFS_PORT4_IN : `OFS_PORT3_IN, d, r);
      chk(d, {24'h0, iv ^ pv}, "inverted sample");
      // a write with the data lane strobe low must change nothing and still answer okay
      wr(p4 ? `OFS_PORT4_OUT : `OFS_PORT3_OUT, {24'h0, ~ov}, r, 4'hE);
      chk(r, `RESP_OKAY, "masked write resp");
      chk(p4 ? port4_pins_o : port3_pins_o, ov ^ pv, "masked lane kept drive");
   endtask : t_port

   // reserved bits, alternate-function driver type, then leaving config state
   task t_otype;
      logic [31:0] d;
      logic [1:0]  r;
      cfg_wr(`IDX_PORT1_OTYP, 8'hFF);
      cfg_rd(`IDX_PORT1_OTYP, d, r);
      chk(d, 32'hCE, "reserved bits read zero");
      chk(port1_open_drain_o, 8'hCE, "open drain pins");
      wr(`OFS_MISC_CTRL, 32'h2, r);
      chk(port1_open_drain_o, 8'hCC, "alt pin push-pull");
      wr(`OFS_MISC_CTRL, 32'h3, r);
      chk(port1_open_drain_o, 8'hCE, "alt pin open drain");
      cfg_wr(`IDX_PORT1_OTYP, 8'h00);
      chk(port1_open_drain_o, 8'h02, "alt pin ignores type reg");
      wr(`OFS_MISC_CTRL, 32'h1, r);
      chk(port1_open_drain_o, 8'h00, "all push-pull");
      wr(`OFS_CFG_CTRL, 32'h0, r);
      cfg_rd(`IDX_PORT3_DIR, d, r);
      chk(r, `RESP_SLVERR, "after leaving config");
   endtask : t_otype

   // ----------------------------------------------------------------------------
   // main sequence and watchdog
   // ----------------------------------------------------------------------------
   initial begin
      logic [1:0] r;
      rst_i = 1; awvalid_i = 0; awaddr_i = 0; wvalid_i = 0; wdata_i = 0;
      wstrb_i = 0; bready_i = 0; arvalid_i = 0; araddr_i = 0; rready_i = 0;
      port3_pins_i = 0; port4_pins_i = 0; n_fail = 0; tests_run = 0;
      do_reset();
      t_denied();
      t_reset_vals();
      t_port(1'b0);
      t_port(1'b1);
      t_otype();
      // second reset mid-run must clear the written registers again
      do_reset();
      chk(port3_pins_oe_n_o, 8'hFF, "second reset");
      chk(port4_pins_oe_n_o, 8'hFF, "second reset");
      // the bus must work again after the mid-run reset and all five registers read zero
      wr(`OFS_CFG_CTRL, 32'h1, r);
      t_reset_vals();
      results();
   end

   // whole run is a few hundred cycles; a hang gets cut well past that
   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_fail++;
      results();
   end
endmodule : tb
